// ==== tw_pkg.sv ====
/*
  constants, field positions and types for the two-wire bus master.
  assumes a single 100 MHz clock and the four printed register addresses.
*/
`default_nettype none
package tw_pkg;
  // register byte addresses
  localparam logic [31:0] TW_ADDR_DATA = 32'h1004_2000;
  localparam logic [31:0] TW_ADDR_CTRL = 32'h1004_2004;
  localparam logic [31:0] TW_ADDR_STAT = 32'h1004_2008;
  localparam logic [31:0] TW_ADDR_DIV = 32'h1004_200c;
  // bus_control fields
  localparam int CTRL_IRQ_ENABLE = 4;
  localparam int CTRL_START_REQUEST = 3;
  localparam int CTRL_STOP_REQUEST = 2;
  localparam int CTRL_ACK_LEVEL_SELECT = 1;
  localparam int CTRL_CONTROLLER_ENABLE = 0;
  // bus_status fields
  localparam int STAT_COND_QUEUE_PENDING = 4;
  localparam int STAT_BUSY = 3;
  localparam int STAT_TRANSFER_IDLE = 2;
  localparam int STAT_DATA_VALID_FLAG = 1;
  localparam int STAT_RECEIVED_ACK_LEVEL = 0;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h04;
  localparam logic [15:0] DIV_RST = 16'h0000;
  // sizes
  localparam int BYTE_W = 8;
  localparam int ENTRY_W = 10;
  localparam int TX_DEPTH = 4;
  localparam int RX_DEPTH = 2;
  localparam int QCNT_W = 17;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [2:0] CMD_CNT_W0 = 3'h0;
  localparam logic [2:0] CMD_ONE = 3'h1;
  // clock rates
  localparam int CLK_HZ = 100_000_000;
  localparam int SCL_MAX_HZ = 400_000;
  // quarter phases of one bus step
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  typedef enum logic [1:0] {
    TW_K_DATA = 2'h0,
    TW_K_START = 2'h1,
    TW_K_STOP = 2'h2
  } tw_kind_e;
  typedef enum logic [1:0] {
    TW_IDLE = 2'h0,
    TW_START = 2'h1,
    TW_BIT = 2'h3,
    TW_STOP = 2'h2
  } tw_state_e;
endpackage
`default_nettype wire

// ==== tw_fifo_if.sv ====
/*
  push/pop carrier between the master core and its queues.
  assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface tw_fifo_if #(parameter int W = 8);
  logic push;
  logic [W-1:0] push_data;
  logic full;
  logic pop;
  logic [W-1:0] pop_data;
  logic empty;
  logic one_left;
  modport store (input push, push_data, pop,
                 output full, pop_data, empty, one_left);
  modport user (output push, push_data, pop,
                input full, pop_data, empty, one_left);
endinterface
`default_nettype wire

// ==== tw_sync.sv ====
/*
  two-flop synchroniser for pin inputs.
  assumes inputs are asynchronous to clk_in.
*/
`timescale 1ns/100ps
`default_nettype none
module tw_sync #(parameter int W = 2) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '1;
      q_out <= '1;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule // tw_sync
`default_nettype wire

// ==== tw_fifo.sv ====
/*
  small first-in first-out store; push ignored when full, pop when empty.
  assumes D is a power of two.
*/
`timescale 1ns/100ps
`default_nettype none
module tw_fifo #(parameter int W = 8, parameter int D = 2) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // queue port
  tw_fifo_if.store q
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  logic [AW:0] level;
  assign level = wr_reg - rd_reg;
  assign q.empty = (wr_reg == rd_reg);
  assign q.full = (level == (AW+1)'(D));
  assign q.one_left = (level == (AW+1)'(1));
  assign q.pop_data = mem[rd_reg[AW-1:0]];
  always_ff @(posedge clk_in) begin
    if (q.push && !q.full) begin
      mem[wr_reg[AW-1:0]] <= q.push_data;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (q.push && !q.full) begin
        wr_reg <= wr_reg + (AW+1)'(1);
      end
      if (q.pop && !q.empty) begin
        rd_reg <= rd_reg + (AW+1)'(1);
      end
    end
  end
endmodule // tw_fifo
`default_nettype wire

// ==== tw_master.sv ====
/*
  single-master two-wire bus controller with queued commands and data.
  assumes a register port on clk_in and open-drain pads outside.
*/
`timescale 1ns/100ps
`default_nettype none
// Function
// RL1 - acts only as the sole bus master, no arbitration.
// RL2 - serial clock rates up to 400 kHz are reachable.
// RL3 - bidirectional data line, clock line times every bit.
// RL4 - transmit and receive paths are double-buffered.
// RL5 - data register is FIFO port: writes enqueue, reads dequeue.
// RL6 - control bit 4 gates the interrupt output.
// RL7 - writing 1 to control bit 3 queues a START.
// RL8 - writing 1 to control bit 2 queues a STOP. Code queues only the START when bit 3 is also written 1.
// RL9 - software writes only 1 to START and STOP bits.
// RL10 - control bit 1 picks acknowledge level sent when receiving.
// RL11 - control bit 0 enables the whole controller.
// RL12 - control and status bits 7:5 read zero, writes ignored.
// RL13 - status bit 4 shows pending START/STOP commands.
// RL14 - status bit 3 shows bus busy.
// RL15 - status bit 2 idle flag, low during byte and ack, resets 1.
// RL16 - status bit 1 data-valid flag, software writable.
// RL17 - status bit 0 holds acknowledge level sampled after sending.
// RL18 - waits while a slave holds the clock low.
// RL19 - general call and START byte sent right after START.
// RL20 - burst transfers of consecutive bytes either direction.
// RL21 - divider bits 15:1 give clock / (16 * rate) - 1.
// RL22 - queued actions run in written order and leave the queue.
// RL23 - interrupt on each byte with ack and on valid data.
module tw_master
  import tw_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [31:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  // serial clock pin
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  // serial data pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // interrupt
  output logic irq_out
);
  tw_fifo_if #(.W(ENTRY_W)) tx_q ();
  tw_fifo_if #(.W(BYTE_W)) rx_q ();

  tw_state_e state_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic rx_byte_reg;
  logic first_byte_reg;
  logic read_mode_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic irq_enable_reg;
  logic ack_level_select_reg;
  logic controller_enable_reg;
  logic [15:0] div_reg;
  logic [QCNT_W-1:0] qcnt_reg;
  logic [2:0] cmd_cnt_reg;
  logic busy_reg;
  logic sda_prev_reg;
  logic data_valid_reg;
  logic received_ack_reg;
  logic byte_done_reg;
  logic irq_reg;
  logic [15:0] rdata_reg;
  logic [1:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic tick;
  logic held;
  logic byte_end;
  logic wr_data;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_div;
  logic rd_data;
  logic rd_stat;
  logic head_cmd;
  logic rx_blocked;
  logic push_cmd;
  logic pop_cmd;
  logic cmd_done;
  logic [7:0] ctrl_view;
  logic [7:0] stat_view;

  // pin inputs
  tw_sync #(.W(2)) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in({scl_in, sda_in}),
    .q_out(pins_sync)
  );
  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  // queues
  tw_fifo #(.W(ENTRY_W), .D(TX_DEPTH)) u_tx (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .q(tx_q.store)
  );
  tw_fifo #(.W(BYTE_W), .D(RX_DEPTH)) u_rx (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .q(rx_q.store)
  );

  // address decode
  assign wr_data = reg_wr_in && (reg_addr_in == TW_ADDR_DATA);
  assign wr_ctrl = reg_wr_in && (reg_addr_in == TW_ADDR_CTRL);
  assign wr_stat = reg_wr_in && (reg_addr_in == TW_ADDR_STAT);
  assign wr_div = reg_wr_in && (reg_addr_in == TW_ADDR_DIV);
  assign rd_data = reg_rd_in && (reg_addr_in == TW_ADDR_DATA);
  assign rd_stat = reg_rd_in && (reg_addr_in == TW_ADDR_STAT);

  // queue writes: data bytes and start/stop share one ordered queue
  assign push_cmd = wr_ctrl && (reg_wdata_in[CTRL_START_REQUEST] ||
                    reg_wdata_in[CTRL_STOP_REQUEST]); // RL7 RL8 RL9
  assign tx_q.push = wr_data || push_cmd; // RL5 RL22
  always_comb begin
    if (wr_ctrl && reg_wdata_in[CTRL_START_REQUEST]) begin
      tx_q.push_data = {TW_K_START, 8'h00}; // RL7
    end else if (wr_ctrl) begin
      tx_q.push_data = {TW_K_STOP, 8'h00}; // RL8
    end else begin
      tx_q.push_data = {TW_K_DATA, reg_wdata_in[BYTE_W-1:0]}; // RL5
    end
  end
  assign head_cmd = (tx_q.pop_data[ENTRY_W-1 -: 2] != TW_K_DATA);
  assign rx_blocked = !head_cmd && read_mode_reg && !first_byte_reg &&
                      rx_q.full; // RL4
  assign tx_q.pop = controller_enable_reg && (state_reg == TW_IDLE) &&
                    !tx_q.empty && !rx_blocked; // RL22
  assign pop_cmd = tx_q.pop && head_cmd;
  // a start/stop stays pending until finished on the wires or disabled while on the wires; a stop on a free bus only until popped
  assign cmd_done = (pop_cmd && !busy_reg &&
                     (tx_q.pop_data[ENTRY_W-1 -: 2] == TW_K_STOP)) ||
                    (((state_reg == TW_START) || (state_reg == TW_STOP)) &&
                     (!controller_enable_reg ||
                      (tick && !held && (phase_reg == PH_FALL)))); // RL22
  assign rx_q.pop = rd_data && !rx_q.empty; // RL5

  // pending command count
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_cnt_reg <= CMD_CNT_W0;
    end else if ((push_cmd && !tx_q.full) && !cmd_done) begin
      cmd_cnt_reg <= cmd_cnt_reg + CMD_ONE; // RL13
    end else if (!(push_cmd && !tx_q.full) && cmd_done) begin
      cmd_cnt_reg <= cmd_cnt_reg - CMD_ONE; // RL13
    end
  end

  // control and divider registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_enable_reg <= CTRL_RST[CTRL_IRQ_ENABLE];
      ack_level_select_reg <= CTRL_RST[CTRL_ACK_LEVEL_SELECT];
      controller_enable_reg <= CTRL_RST[CTRL_CONTROLLER_ENABLE];
    end else if (wr_ctrl) begin
      irq_enable_reg <= reg_wdata_in[CTRL_IRQ_ENABLE]; // RL6
      ack_level_select_reg <= reg_wdata_in[CTRL_ACK_LEVEL_SELECT]; // RL10
      controller_enable_reg <= reg_wdata_in[CTRL_CONTROLLER_ENABLE]; // RL11
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg <= DIV_RST;
    end else if (wr_div) begin
      div_reg <= reg_wdata_in;
    end
  end

  // quarter-bit tick: four ticks per bit, 16 * (divider bits 15:1 + 1) clocks
  assign tick = (qcnt_reg == {div_reg[15:1], 2'h3}); // RL21 RL2
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      qcnt_reg <= '0;
    end else if (tick || !controller_enable_reg) begin
      qcnt_reg <= '0;
    end else begin
      qcnt_reg <= qcnt_reg + QCNT_W'(1);
    end
  end

  // a released clock that still reads low is a slave stretching it
  assign held = (phase_reg == PH_HIGH) && !scl_s; // RL18
  assign byte_end = (state_reg == TW_BIT) && tick && !held &&
                    (phase_reg == PH_FALL) && (bit_cnt_reg == ACK_SLOT);

  // bus engine; sole master, never checks for lost arbitration
  always_ff @(posedge clk_in or negedge rst_n_in) begin // RL1
    if (!rst_n_in) begin
      state_reg <= TW_IDLE;
      phase_reg <= PH_SETUP;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      rx_byte_reg <= 1'b0;
      first_byte_reg <= 1'b0;
      read_mode_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      received_ack_reg <= STAT_RST[STAT_RECEIVED_ACK_LEVEL];
    end else if (!controller_enable_reg) begin
      state_reg <= TW_IDLE; // RL11
      phase_reg <= PH_SETUP;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        TW_IDLE: begin
          phase_reg <= PH_SETUP;
          bit_cnt_reg <= '0;
          if (tx_q.pop) begin
            shift_reg <= tx_q.pop_data[BYTE_W-1:0];
            rx_byte_reg <= read_mode_reg && !first_byte_reg; // RL20
            unique case (tx_q.pop_data[ENTRY_W-1 -: 2])
              TW_K_START: state_reg <= TW_START; // RL22
              TW_K_STOP: state_reg <= busy_reg ? TW_STOP : TW_IDLE;
              default: state_reg <= TW_BIT; // RL22
            endcase
          end
        end
        TW_START: begin
          if (tick && !held) begin
            phase_reg <= phase_reg + 2'h1;
            unique case (phase_reg)
              PH_SETUP: sda_oe_reg <= 1'b0;
              PH_RISE: scl_oe_reg <= 1'b0;
              PH_HIGH: sda_oe_reg <= 1'b1; // RL7
              PH_FALL: begin
                scl_oe_reg <= 1'b1;
                state_reg <= TW_IDLE;
                first_byte_reg <= 1'b1; // RL19
                read_mode_reg <= 1'b0;
              end
            endcase
          end
        end
        TW_BIT: begin
          if (tick && !held) begin
            phase_reg <= phase_reg + 2'h1;
            unique case (phase_reg)
              PH_SETUP: begin
                if (bit_cnt_reg == ACK_SLOT) begin
                  sda_oe_reg <= rx_byte_reg && !ack_level_select_reg; // RL10
                end else begin
                  sda_oe_reg <= !rx_byte_reg && !shift_reg[7]; // RL3
                end
              end
              PH_RISE: scl_oe_reg <= 1'b0;
              PH_HIGH: begin
                if (bit_cnt_reg == ACK_SLOT) begin
                  if (!rx_byte_reg) begin
                    received_ack_reg <= sda_s; // RL17
                  end
                end else begin
                  shift_reg <= {shift_reg[6:0], sda_s}; // RL3
                end
              end
              PH_FALL: begin
                scl_oe_reg <= 1'b1;
                if (bit_cnt_reg == ACK_SLOT) begin
                  state_reg <= TW_IDLE;
                  first_byte_reg <= 1'b0;
                  if (first_byte_reg) begin
                    read_mode_reg <= shift_reg[0]; // RL20
                  end
                end else begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
              end
            endcase
          end
        end
        TW_STOP: begin
          if (tick && !held) begin
            phase_reg <= phase_reg + 2'h1;
            unique case (phase_reg)
              PH_SETUP: begin
                scl_oe_reg <= 1'b1;
                sda_oe_reg <= 1'b1;
              end
              PH_RISE: scl_oe_reg <= 1'b0;
              PH_HIGH: sda_oe_reg <= 1'b0; // RL8
              PH_FALL: begin
                state_reg <= TW_IDLE;
                read_mode_reg <= 1'b0;
              end
            endcase
          end
        end
      endcase
    end
  end

  // received bytes enter the receive queue after their ack slot
  assign rx_q.push = byte_end && rx_byte_reg; // RL4
  assign rx_q.push_data = shift_reg;

  // bus busy from start/stop seen on the wires
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sda_prev_reg <= 1'b1;
      busy_reg <= STAT_RST[STAT_BUSY];
    end else begin
      sda_prev_reg <= sda_s;
      if (scl_s && sda_prev_reg && !sda_s) begin
        busy_reg <= 1'b1; // RL14
      end else if (scl_s && !sda_prev_reg && sda_s) begin
        busy_reg <= 1'b0; // RL14
      end
    end
  end

  // data-valid flag: hardware set beats software write
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_valid_reg <= STAT_RST[STAT_DATA_VALID_FLAG];
    end else if (rx_q.push) begin
      data_valid_reg <= 1'b1; // RL16
    end else if (wr_stat) begin
      data_valid_reg <= reg_wdata_in[STAT_DATA_VALID_FLAG]; // RL16
    end else if (rx_q.pop && rx_q.one_left) begin
      data_valid_reg <= 1'b0;
    end
  end

  // byte-complete event, cleared by a status read
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      byte_done_reg <= 1'b0;
    end else if (byte_end) begin
      byte_done_reg <= 1'b1; // RL23
    end else if (rd_stat) begin
      byte_done_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_enable_reg && (byte_done_reg || data_valid_reg); // RL6 RL23
    end
  end

  // register read views
  assign ctrl_view = {3'h0, irq_enable_reg, 2'h0, ack_level_select_reg,
                      controller_enable_reg}; // RL12
  assign stat_view = {3'h0, (cmd_cnt_reg != CMD_CNT_W0), busy_reg,
                      (state_reg == TW_IDLE), data_valid_reg,
                      received_ack_reg}; // RL12 RL13 RL15
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= '0;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        TW_ADDR_DATA: rdata_reg <= {8'h00, rx_q.pop_data}; // RL5
        TW_ADDR_CTRL: rdata_reg <= {8'h00, ctrl_view};
        TW_ADDR_STAT: rdata_reg <= {8'h00, stat_view};
        TW_ADDR_DIV: rdata_reg <= div_reg;
        default: rdata_reg <= '0;
      endcase
    end
  end

  // outputs; pads are open-drain, only ever pulled low
  assign reg_rdata_out = rdata_reg;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = scl_oe_reg;
  assign sda_oe_out = sda_oe_reg;
  assign irq_out = irq_reg;
endmodule // tw_master
`default_nettype wire

// ==== tw_slave.sv ====
/*
  behavioural bus slave: acks its address, keeps written bytes,
  answers reads from a table. assumes pulled-up wires outside.
*/
`timescale 1ns/100ps
`default_nettype none
module tw_slave #(parameter logic [6:0] ADDR = 7'h52) (
  // bus wires
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe_out,
  output logic sda_oe_out,
  // control and observation
  input wire logic stretch_in,
  output logic [7:0] addr_out,
  output logic [15:0] bytes_out,
  output logic [1:0] macks_out
);
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h96;
  int bitn = 9;
  logic first = 1'b0;
  logic sel = 1'b0;
  logic rdm = 1'b0;
  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
    addr_out = 8'h00;
    bytes_out = 16'h0000;
    macks_out = 2'b00;
  end
  // start condition
  always @(negedge sda_in) if (scl_in) begin
    bitn = 9;
    first = 1'b1;
    rdm = 1'b0;
  end
  // stop condition frees the slave
  always @(posedge sda_in) if (scl_in) begin
    sel = 1'b0;
    rdm = 1'b0;
  end
  always @(posedge scl_in) begin
    if (bitn < 8) sh = {sh[6:0], sda_in};
    else if (bitn == 8 && rdm) macks_out = {macks_out[0], sda_in};
  end
  always @(negedge scl_in) begin
    if (bitn == 8) begin
      bitn = 0;
      if (first) rdm = sel & sh[0];
      else if (rdm) rdm = !macks_out[0];
      tx = first ? 8'h96 : 8'h5a;
      first = 1'b0;
    end else begin
      bitn = (bitn >= 8) ? 0 : bitn + 1;
    end
    if (bitn == 8 && !rdm) begin
      if (first) begin
        addr_out = sh;
        sel = (sh[7:1] == ADDR);
      end else if (sel) bytes_out = {bytes_out[7:0], sh};
    end
    sda_oe_out = rdm ? (bitn < 8 && !tx[7 - bitn]) : (bitn == 8 && sel);
    // slow answer: hold the clock low in the ack slot
    if (bitn == 8 && stretch_in) begin
      scl_oe_out = 1'b1;
      #400;
      scl_oe_out = 1'b0;
    end
  end
endmodule // tw_slave
`default_nettype wire

// ==== tw_master_properties.sv ====
/*
  port checks for tw_master.
  assumes one clock domain and the pin wiring of the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module tw_master_properties
  import tw_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [31:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  // pins
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_out,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic irq_out
);
  logic ien_reg;
  logic en_reg;
  logic [14:0] div_reg;
  wire logic ctrl_wr = reg_wr_in && reg_addr_in == TW_ADDR_CTRL;
  wire logic rd_c = reg_rd_in && reg_addr_in == TW_ADDR_CTRL;
  wire logic rd_s = reg_rd_in && reg_addr_in == TW_ADDR_STAT;
  wire logic rd_d = reg_rd_in && reg_addr_in == TW_ADDR_DIV;
  wire logic rd_u = reg_rd_in && !rd_c && !rd_s && !rd_d &&
    reg_addr_in != TW_ADDR_DATA;
  // shadow of written fields
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ien_reg <= 1'b0;
      en_reg <= 1'b0;
      div_reg <= 15'h0000;
    end else begin
      if (ctrl_wr) ien_reg <= reg_wdata_in[4];
      if (ctrl_wr) en_reg <= reg_wdata_in[0];
      if (reg_wr_in && reg_addr_in == TW_ADDR_DIV)
        div_reg <= reg_wdata_in[15:1];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_pins_open_drain: assert property (!scl_out && !sda_out)
    else $error("pin output not low");
  a_ctrl_reserved_zero: assert property (
    rd_c |=> reg_rdata_out[15:5] == 11'h000 && reg_rdata_out[3:2] == 2'h0)
    else $error("control reads reserved bits");
  a_stat_reserved_zero: assert property (
    rd_s |=> reg_rdata_out[15:5] == 11'h000)
    else $error("status reads reserved bits");
  a_unmapped_zero: assert property (rd_u |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (
    rd_c |=> reg_rdata_out[4] == $past(ien_reg) &&
      reg_rdata_out[0] == $past(en_reg))
    else $error("control readback wrong");
  a_div_readback: assert property (
    rd_d |=> reg_rdata_out[15:1] == $past(div_reg))
    else $error("divider readback wrong");
  a_irq_gated_off: assert property (
    !ien_reg && !$past(ien_reg) |-> !irq_out)
    else $error("interrupt while disabled");
  a_disable_release: assert property (
    ctrl_wr && !reg_wdata_in[0] |-> ##[1:4] (!scl_oe_out && !sda_oe_out))
    else $error("lines held after disable");
  a_stretch_hold: assert property (
    !scl_oe_out && !scl_in |=> !scl_oe_out)
    else $error("clock pulled during stretch");
  a_stop_gap: assert property (
    $fell(sda_oe_out) && !scl_oe_out && scl_in |=> !sda_oe_out [*4])
    else $error("bus reused too soon after stop");
  a_start_on_high: assert property (
    $rose(sda_oe_out) && !scl_oe_out |-> scl_in)
    else $error("start while clock low");
endmodule // tw_master_properties
bind tw_master tw_master_properties u_props (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .irq_out(irq_out));
`default_nettype wire

// ==== tb_top.sv ====
/*
  self-checking bench for tw_master with a slave model.
  assumes the slave answers at 7'h52 behind pulled-up wires.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tw_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [31:0] reg_addr_in = TW_ADDR_DATA;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic [15:0] reg_rdata_out, rv;
  logic scl_out, scl_oe_out, sda_out, sda_oe_out, irq_out;
  logic s_scl_oe, s_sda_oe;
  logic stretch = 1'b0;
  logic [7:0] s_addr;
  logic [15:0] s_bytes;
  logic [1:0] s_macks;
  wire logic scl = !(scl_oe_out | s_scl_oe);
  wire logic sda = !(sda_oe_out | s_sda_oe);
  int fail_count = 0;
  int total_checks = 0;
  tw_master dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .scl_in(scl), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .irq_out(irq_out));
  tw_slave slave (
    .scl_in(scl), .sda_in(sda), .scl_oe_out(s_scl_oe),
    .sda_oe_out(s_sda_oe), .stretch_in(stretch), .addr_out(s_addr),
    .bytes_out(s_bytes), .macks_out(s_macks));
  initial forever #5 clk_in = ~clk_in;
  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    rv = reg_rdata_out;
  endtask
  // idle three reads in a row, bounded
  task automatic wait_idle();
    int n;
    int ok;
    ok = 0;
    for (n = 0; n < 2000 && ok < 3; n++) begin
      rd(TW_ADDR_STAT);
      ok = (rv[4] === 1'b0 && rv[2] === 1'b1) ? ok + 1 : 0;
    end
    if (ok < 3) begin
      fail_count++;
      $display("[FAIL] %0t wait for idle timed out", $time);
      print_verdict();
    end
  endtask
  task automatic t_regs();
    rd(TW_ADDR_CTRL);
    check(rv, 16'h0000);
    rd(TW_ADDR_STAT);
    check(rv, 16'h0004);
    rd(TW_ADDR_DIV);
    check(rv, 16'h0000);
    rd(32'h1004_2010);
    check(rv, 16'h0000);
    wr(TW_ADDR_CTRL, 16'h00f2);
    rd(TW_ADDR_CTRL);
    check(rv, 16'h0012);
    wr(TW_ADDR_STAT, 16'h00e2);
    rd(TW_ADDR_STAT);
    check(rv, 16'h0006);
    wr(TW_ADDR_STAT, 16'h0000);
    wr(TW_ADDR_CTRL, 16'h0000);
    wr(TW_ADDR_DIV, 16'h0002);
    rd(TW_ADDR_DIV);
    check(rv, 16'h0002);
  endtask
  task automatic t_write();
    wr(TW_ADDR_CTRL, 16'h0001);
    wr(TW_ADDR_CTRL, 16'h0009);
    rd(TW_ADDR_STAT);
    check(rv & 16'h0010, 16'h0010);
    wr(TW_ADDR_DATA, 16'h00a4);
    wr(TW_ADDR_DATA, 16'h003c);
    wr(TW_ADDR_DATA, 16'h00c3);
    repeat (60) @(negedge clk_in);
    rd(TW_ADDR_STAT);
    check(rv & 16'h0008, 16'h0008);
    wr(TW_ADDR_CTRL, 16'h0005);
    wait_idle();
    check({8'h00, s_addr}, 16'h00a4);
    check(s_bytes, 16'h3cc3);
    rd(TW_ADDR_STAT);
    check(rv, 16'h0004);
  endtask
  task automatic t_nack();
    wr(TW_ADDR_CTRL, 16'h0009);
    wr(TW_ADDR_DATA, 16'h0000);
    wr(TW_ADDR_CTRL, 16'h0005);
    wait_idle();
    check({8'h00, s_addr}, 16'h0000);
    rd(TW_ADDR_STAT);
    check(rv, 16'h0005);
  endtask
  task automatic t_read();
    stretch = 1'b1;
    wr(TW_ADDR_CTRL, 16'h0019);
    wr(TW_ADDR_DATA, 16'h00a5);
    wr(TW_ADDR_DATA, 16'h0000);
    wait_idle();
    rd(TW_ADDR_STAT);
    check(rv, 16'h000e);
    check({15'h0000, irq_out}, 16'h0001);
    rd(TW_ADDR_DATA);
    check(rv, 16'h0096);
    wr(TW_ADDR_CTRL, 16'h0003);
    wr(TW_ADDR_DATA, 16'h0000);
    wait_idle();
    check({15'h0000, irq_out}, 16'h0000);
    rd(TW_ADDR_DATA);
    check(rv, 16'h005a);
    wr(TW_ADDR_CTRL, 16'h0005);
    wait_idle();
    check({14'h0000, s_macks}, 16'h0001);
  endtask
  task automatic t_abort();
    wr(TW_ADDR_CTRL, 16'h0009);
    wr(TW_ADDR_DATA, 16'h00a4);
    repeat (60) @(negedge clk_in);
    wr(TW_ADDR_CTRL, 16'h0000);
    repeat (30) @(negedge clk_in);
    check({14'h0000, scl, sda}, 16'h0003);
  endtask
  initial begin
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_regs();
    t_write();
    t_nack();
    t_read();
    t_abort();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
